// ---- rtl/pmd_driver.sv ----
// pointer motor pwm driver: apb registers, shared counter, seven units, rotor detect
// Notes on behaviour
// - one 8-bit free-running up counter feeds every unit
// - each unit compares its sine and cosine values with the counter
// - output flop sets at counter zero, clears on compare match
// - each unit delays its flop outputs by its own fixed cycle count
// - quadrant setting routes two pwm signals onto four bridge lines
// - buffered unit/quadrant, sine, cosine move to the chosen unit together
// - sine write sets busy; transfer at next counter zero, within 256 cycles
// - transfer clears busy; unit uses new values at once
// - after reset the module is idle with all motor lines low
// - enable starts the counter; outputs stay low until values loaded
// - writing 1 to a detect bit starts comparator sampling
// - result reads 1 only after three consecutive 1 samples, one clock apart
// - writing 0 to a detect bit stops sampling and clears the result
// - detection runs on all units at once, independently
// - clearing enable stops counter, zeroes outputs, clears state, powers comparators down
// - pwm period is 256 module clock cycles
// - unit select codes 0 to 6 pick units, code 7 is ignored
// - quadrant 00/01/10/11 route sine and cosine as per table, others low
// - value n gives duty n/256; never continuously high
// - busy reads at bit 0 of the sine buffer address
//
// The APB register port and the register offsets were decided locally.
module pmd_driver
  import pmd_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [pmd_pkg::N_UNITS-1:0] rotor_cmp_in,
  output logic                          comparator_supply_en,
  output logic      [pmd_pkg::N_UNITS-1:0] bridge1_plus_out,
  output logic      [pmd_pkg::N_UNITS-1:0] bridge1_minus_out,
  output logic      [pmd_pkg::N_UNITS-1:0] bridge2_plus_out,
  output logic      [pmd_pkg::N_UNITS-1:0] bridge2_minus_out
);
  import pmd_pkg::*;

  pmd_state_s st_r;
  pmd_state_s st_nxt;
  logic       setup;
  logic       wr;
  logic       hit;

  // apb phase decode
  assign setup = psel & ~penable;
  assign wr    = psel & penable & st_r.pready & pwrite;
  assign hit   = (paddr == ADDR_UQ) | (paddr == ADDR_COS) | (paddr == ADDR_SIN) |
                 (paddr == ADDR_DET) | (paddr == ADDR_CTRL);

  // next state of the whole block
  always_comb begin
    pmd_state_s hold;
    logic [1:0] p;
    logic [7:0] cv;
    hold   = PMD_RST;
    p      = 2'h0;
    cv     = 8'h00;
    st_nxt = st_r;
    // apb slave: answer in the cycle after setup
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~hit;
    st_nxt.prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        ADDR_UQ:   st_nxt.prdata = {24'h00_0000, st_r.uq_buf};
        ADDR_COS:  st_nxt.prdata = {24'h00_0000, st_r.cos_buf};
        ADDR_SIN:  st_nxt.prdata = {31'h0000_0000, st_r.busy};
        ADDR_DET:  st_nxt.prdata = {25'h000_0000, st_r.det_res};
        ADDR_CTRL: st_nxt.prdata = {31'h0000_0000, st_r.en};
        default:   st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // shared counter, wraps every 256 cycles
    st_nxt.cnt = 8'(st_r.cnt + 8'h01);
    // scheduler download one cycle before the counter returns to zero
    if (st_r.busy && st_r.cnt == CNT_TOP) begin
      st_nxt.busy = 1'b0;
      for (int i = 0; i < N_UNITS; i++) begin
        if (st_r.uq_buf[SEL_LSB+:3] != SEL_BAD && st_r.uq_buf[SEL_LSB+:3] == 3'(i)) begin
          st_nxt.sin_u[i]  = st_r.sin_buf;
          st_nxt.cos_u[i]  = st_r.cos_buf;
          st_nxt.quad_u[i] = st_r.uq_buf[1:0];
        end
      end
    end
    // per unit pwm, delay, routing and detection
    for (int i = 0; i < N_UNITS; i++) begin
      for (int c = 0; c < 2; c++) begin
        cv = (c == 0) ? st_r.sin_u[i] : st_r.cos_u[i];
        if (st_r.cnt == cv) begin
          st_nxt.pwm[i][c] = 1'b0;
        end else if (st_r.cnt == CNT_ZERO) begin
          st_nxt.pwm[i][c] = 1'b1;
        end
      end
      st_nxt.dly[i][0] = st_r.pwm[i];
      for (int k = 1; k < N_UNITS; k++) begin
        st_nxt.dly[i][k] = st_r.dly[i][k-1];
      end
      p = st_r.dly[i][i];
      case (st_r.quad_u[i])
        QUAD_00: st_nxt.out[i] = {1'b0, p[1], 1'b0, p[0]};
        QUAD_01: st_nxt.out[i] = {p[1], 1'b0, 1'b0, p[0]};
        QUAD_10: st_nxt.out[i] = {p[1], 1'b0, p[0], 1'b0};
        default: st_nxt.out[i] = {1'b0, p[1], p[0], 1'b0};
      endcase
      // three consecutive ones on the filtered comparator set the result
      if (!st_r.det_en[i]) begin
        st_nxt.hits[i]    = 2'h0;
        st_nxt.det_res[i] = 1'b0;
      end else if (st_r.filt[i]) begin
        st_nxt.hits[i] = (st_r.hits[i] == DET_HITS) ? DET_HITS : 2'(st_r.hits[i] + 2'h1);
        if (st_nxt.hits[i] == DET_HITS) begin
          st_nxt.det_res[i] = 1'b1;
        end
      end else begin
        st_nxt.hits[i] = 2'h0;
      end
    end
    // pin synchroniser and agreement filter
    st_nxt.s1   = rotor_cmp_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 | st_r.s3));
    // register writes, taken at the access edge
    if (wr) begin
      case (paddr)
        ADDR_UQ:   st_nxt.uq_buf  = pwdata[7:0];
        ADDR_COS:  st_nxt.cos_buf = pwdata[7:0];
        ADDR_SIN: begin
          st_nxt.sin_buf = pwdata[7:0];
          st_nxt.busy    = 1'b1;
        end
        ADDR_DET: begin
          st_nxt.det_en = pwdata[6:0];
          for (int i = 0; i < N_UNITS; i++) begin
            if (!pwdata[i]) begin
              st_nxt.hits[i]    = 2'h0;
              st_nxt.det_res[i] = 1'b0;
            end
          end
        end
        ADDR_CTRL: st_nxt.en = pwdata[EN_BIT];
        default:   st_nxt.en = st_nxt.en;
      endcase
    end
    // standby clears everything but the bus answer
    if (!st_nxt.en) begin
      hold         = PMD_RST;
      hold.pready  = st_nxt.pready;
      hold.prdata  = st_nxt.prdata;
      hold.pslverr = st_nxt.pslverr;
      st_nxt       = hold;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= PMD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata               = st_r.prdata;
  assign pready               = st_r.pready;
  assign pslverr              = st_r.pslverr;
  assign comparator_supply_en = st_r.en;

  generate
    for (genvar g = 0; g < N_UNITS; g++) begin : g_out
      assign bridge1_plus_out[g]  = st_r.out[g][0];
      assign bridge1_minus_out[g] = st_r.out[g][1];
      assign bridge2_plus_out[g]  = st_r.out[g][2];
      assign bridge2_minus_out[g] = st_r.out[g][3];
    end
  endgenerate

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic en_stays;
  assign en_stays = st_r.en & ~(wr & (paddr == ADDR_CTRL) & ~pwdata[EN_BIT]);

  sequence sine_wr;
    wr && paddr == ADDR_SIN;
  endsequence

  sequence three_hits;
    (st_r.det_en[0] && st_r.filt[0]) [*3];
  endsequence

  a_cnt_step: assert property (en_stays |=> st_r.cnt == 8'($past(st_r.cnt) + 8'h01))
    else $error("counter did not step");
  a_cnt_wrap: assert property (en_stays && st_r.cnt == CNT_TOP |=> st_r.cnt == CNT_ZERO)
    else $error("counter did not wrap");
  a_pwm_set: assert property (en_stays && st_r.cnt == CNT_ZERO && st_r.sin_u[0] != CNT_ZERO
                              |=> st_r.pwm[0][0])
    else $error("pwm not set at zero");
  a_match_clear: assert property (st_r.en && st_r.cnt == st_r.cos_u[0] |=> !st_r.pwm[0][1])
    else $error("pwm not cleared on match");
  a_busy_set: assert property (sine_wr and (st_r.en && en_stays) |=> st_r.busy)
    else $error("busy not set by sine write");
  a_busy_bound: assert property ($rose(st_r.busy) |-> ##[1:257] !st_r.busy)
    else $error("transfer too late");
  a_xfer_use: assert property (st_r.busy && !st_nxt.busy && st_r.en && st_nxt.en &&
                               st_r.uq_buf[SEL_LSB+:3] == 3'h0 |=> st_r.sin_u[0] == $past(st_r.sin_buf))
    else $error("sine not downloaded");
  a_standby_low: assert property (!st_r.en |-> st_r.out == '0 && !comparator_supply_en)
    else $error("outputs not low in standby");
  a_det_three: assert property ($rose(st_r.det_res[0]) |->
                                $past(st_r.filt[0]) && $past(st_r.filt[0], 2) && $past(st_r.filt[0], 3))
    else $error("result set too early");
  a_det_seen: assert property (three_hits ##1 st_r.det_en[0] && st_nxt.det_en[0] |=> st_r.det_res[0])
    else $error("result missing after three ones");
  a_det_clear: assert property (wr && paddr == ADDR_DET && !pwdata[0] |=> !st_r.det_res[0])
    else $error("result not cleared");

  // sine match clears the sine flop of unit 0
  a_sin_clear: assert property (en_stays && st_r.cnt == st_r.sin_u[0] |=> !st_r.pwm[0][0])
    else $error("sine pwm not cleared on match");

  // busy reads back at bit 0 of the sine address
  a_busy_read: assert property (setup && !pwrite && paddr == ADDR_SIN |=> prdata == {31'h0000_0000, $past(st_r.busy)})
    else $error("busy not readable");

  // quadrant 00 keeps both minus lines low
  a_route_00: assert property (en_stays && st_r.quad_u[0] == QUAD_00 |=> !bridge1_minus_out[0] && !bridge2_minus_out[0])
    else $error("quadrant 00 routing wrong");

  // quadrant 01 keeps bridge1 minus and bridge2 plus low
  a_route_01: assert property (en_stays && st_r.quad_u[0] == QUAD_01 |=> !bridge1_minus_out[0] && !bridge2_plus_out[0])
    else $error("quadrant 01 routing wrong");

  // quadrant 10 keeps both plus lines low
  a_route_10: assert property (en_stays && st_r.quad_u[0] == QUAD_10 |=> !bridge1_plus_out[0] && !bridge2_plus_out[0])
    else $error("quadrant 10 routing wrong");

  // quadrant 11 keeps bridge1 plus and bridge2 minus low
  a_route_11: assert property (en_stays && st_r.quad_u[0] == 2'h3 |=> !bridge1_plus_out[0] && !bridge2_minus_out[0])
    else $error("quadrant 11 routing wrong");

  // unit 3 lags its sine flop by four stages and the output flop
  a_lag_three: assert property (en_stays && st_r.quad_u[3] == QUAD_00 |=>
                                bridge1_plus_out[3] == $past(st_r.pwm[3][0], 5))
    else $error("unit 3 delay wrong");

  // unit 6 lags its sine flop by seven stages and the output flop
  a_lag_six: assert property (en_stays && st_r.quad_u[6] == QUAD_00 |=>
                              bridge1_plus_out[6] == $past(st_r.pwm[6][0], 8))
    else $error("unit 6 delay wrong");

  // counter held at zero while in standby
  a_cnt_hold: assert property (!st_r.en && !st_nxt.en |=> st_r.cnt == CNT_ZERO)
    else $error("counter runs in standby");

  // download at counter top clears busy unless a new sine write lands
  a_busy_clear: assert property (en_stays && st_r.busy && st_r.cnt == CNT_TOP &&
                                 !(wr && paddr == ADDR_SIN) |=> !st_r.busy)
    else $error("busy not cleared by download");

  // forbidden select code leaves every unit untouched
  a_bad_sel: assert property (en_stays && st_r.busy && st_r.cnt == CNT_TOP &&
                              st_r.uq_buf[SEL_LSB+:3] == SEL_BAD |=> st_r.sin_u == $past(st_r.sin_u))
    else $error("forbidden select changed a unit");

  // unit 5 detection runs on its own
  a_det_par: assert property (en_stays && st_r.det_en[5] && st_r.filt[5] && st_r.hits[5] == 2'h2 &&
                              !(wr && paddr == ADDR_DET) |=> st_r.det_res[5])
    else $error("unit 5 result missing");

  // no result while sampling is off
  a_det_off: assert property (!st_r.det_en[1] |=> !st_r.det_res[1])
    else $error("result without sampling");
endmodule

// ---- rtl/pmd_pkg.sv ----
// constants, register map and state record of the pointer motor pwm driver
package pmd_pkg;
  localparam int          N_UNITS     = 7;
  localparam logic [11:0] ADDR_UQ     = 12'h000; // unit_quadrant_buffer
  localparam logic [11:0] ADDR_COS    = 12'h004; // cosine_buffer
  localparam logic [11:0] ADDR_SIN    = 12'h008; // sine_buffer, busy on read
  localparam logic [11:0] ADDR_DET    = 12'h00C; // rotor_detect_control
  localparam logic [11:0] ADDR_CTRL   = 12'h010; // motor_module_enable
  localparam int          SEL_LSB     = 3;
  localparam logic [2:0]  SEL_BAD     = 3'h7;
  localparam int          BUSY_BIT    = 0;
  localparam int          EN_BIT      = 0;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  localparam logic [7:0]  CNT_TOP     = 8'hFF;
  localparam logic [1:0]  DET_HITS    = 2'h3;
  localparam logic [1:0]  QUAD_00     = 2'h0;
  localparam logic [1:0]  QUAD_01     = 2'h1;
  localparam logic [1:0]  QUAD_10     = 2'h2;
  localparam int          PCLK_NS     = 25;
  localparam int          PWM_PERIOD  = 256;               // cycles per pwm period
  localparam int          XFER_MAX_NS = PWM_PERIOD * PCLK_NS; // longest wait for transfer
  localparam int          XFER_MAX    = XFER_MAX_NS / PCLK_NS;

  typedef struct packed {
    logic                 en;
    logic [7:0]           cnt;
    logic [7:0]           uq_buf;
    logic [7:0]           cos_buf;
    logic [7:0]           sin_buf;
    logic                 busy;
    logic [6:0][7:0]      sin_u;
    logic [6:0][7:0]      cos_u;
    logic [6:0][1:0]      quad_u;
    logic [6:0][1:0]      pwm;
    logic [6:0][6:0][1:0] dly;
    logic [6:0][3:0]      out;
    logic [6:0]           det_en;
    logic [6:0]           det_res;
    logic [6:0][1:0]      hits;
    logic [6:0]           s1;
    logic [6:0]           s2;
    logic [6:0]           s3;
    logic [6:0]           filt;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
  } pmd_state_s;

  localparam pmd_state_s PMD_RST = '0;
endpackage

// ---- verif/pmd_coil_model.sv ----
// coil and comparator stand-in at the bridge1 plus output of every unit
module pmd_coil_model (
  input  wire logic       pclk,
  input  wire logic [6:0] b1p,
  input  wire logic [6:0] emf,
  output logic      [6:0] cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // induced voltage only reaches the comparator while its line is not driven
  always_ff @(posedge pclk) begin
    cmp <= emf & ~b1p;
  end
endmodule

// ---- verif/tb_pointer_motor_pwm_driver.sv ----
// self-checking bench of the pointer motor pwm driver
module tb_pointer_motor_pwm_driver;
  import pmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, perr, pslverr, sup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  cmp, emf, b1p, b1m, b2p, b2m;
  int          mismatches, tests_run, c[4];

  pmd_driver pmd_driver_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rotor_cmp_in(cmp), .comparator_supply_en(sup), .bridge1_plus_out(b1p),
    .bridge1_minus_out(b1m), .bridge2_plus_out(b2p), .bridge2_minus_out(b2m));
  pmd_coil_model pmd_coil_model_inst (.pclk(pclk), .b1p(b1p), .emf(emf), .cmp(cmp));

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // buffered load in documented order, then wait for busy to clear
  task automatic load(input logic [2:0] u, input logic [1:0] q, input logic [7:0] s, input logic [7:0] cv);
    time t0;
    int  n;
    apb(1'b1, ADDR_UQ, 32'(u) << SEL_LSB | 32'(q));
    apb(1'b1, ADDR_COS, 32'(cv));
    apb(1'b1, ADDR_SIN, 32'(s));
    t0 = $time;
    apb(1'b0, ADDR_SIN, 32'h0);
    check(rd[BUSY_BIT] === 1'b1, "busy not set");
    n = 0;
    do begin
      apb(1'b0, ADDR_SIN, 32'h0);
      n++;
    end while (rd[BUSY_BIT] !== 1'b0 && n < 100);
    check($time - t0 <= (PWM_PERIOD + 8) * PCLK_NS, "transfer too late");
  endtask

  // high cycles of one unit's four lines over one pwm period
  task automatic expect4(input int u, input int e0, input int e1, input int e2, input int e3);
    repeat (300) @(posedge pclk);
    c = '{0, 0, 0, 0};
    repeat (PWM_PERIOD) begin
      @(posedge pclk);
      c[0] += int'(b1p[u] === 1'b1);
      c[1] += int'(b1m[u] === 1'b1);
      c[2] += int'(b2p[u] === 1'b1);
      c[3] += int'(b2m[u] === 1'b1);
    end
    check(c[0] == e0 && c[1] == e1 && c[2] == e2 && c[3] == e3, "line duty wrong");
  endtask

  task automatic t_reset();
    check({b1p, b1m, b2p, b2m, sup} === '0, "lines not low after reset");
    apb(1'b0, ADDR_DET, 32'h0);
    check(rd === 32'h0 && perr === 1'b0, "detect not clear");
    apb(1'b0, 12'h020, 32'h0);
    check(perr === 1'b1, "unmapped not refused");
  endtask

  task automatic t_quads();
    apb(1'b1, ADDR_CTRL, 32'h1);
    check(sup === 1'b1, "supply off");
    expect4(3, 0, 0, 0, 0);
    for (int q = 0; q < 4; q++) begin
      load(3'h3, 2'(q), 8'h40, 8'hA0);
      expect4(3, q < 2 ? 'h40 : 0, q < 2 ? 0 : 'h40, q % 3 == 0 ? 'hA0 : 0, q % 3 == 0 ? 0 : 'hA0);
    end
  endtask

  task automatic t_edges();
    load(3'h6, QUAD_00, 8'h00, 8'hFF);
    expect4(6, 0, 0, 255, 0);
    load(3'h0, QUAD_00, 8'h01, 8'h80);
    expect4(0, 1, 0, 'h80, 0);
    expect4(3, 0, 'h40, 'hA0, 0);
    load(SEL_BAD, QUAD_01, 8'h11, 8'h22);
    expect4(6, 0, 0, 255, 0);
  endtask

  task automatic t_detect();
    apb(1'b1, ADDR_DET, 32'h27);
    emf <= 7'h25;
    @(posedge pclk);
    emf[1] <= 1'b1;
    repeat (2) @(posedge pclk);
    emf[1] <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_DET, 32'h0);
    check(rd[6:0] === 7'h25, "detect result wrong");
    apb(1'b1, ADDR_DET, 32'h20);
    apb(1'b0, ADDR_DET, 32'h0);
    check(rd[6:0] === 7'h20, "detect not cleared");
  endtask

  task automatic t_disable();
    apb(1'b1, ADDR_CTRL, 32'h0);
    check({b1p, b1m, b2p, b2m, sup} === '0, "lines not low when disabled");
    apb(1'b0, ADDR_DET, 32'h0);
    check(rd === 32'h0, "detect kept");
    apb(1'b1, ADDR_CTRL, 32'h1);
    expect4(6, 0, 0, 0, 0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #(20000 * PCLK_NS);
    mismatches++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, emf} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_quads();
    t_edges();
    t_detect();
    t_disable();
    stop_test();
  end
endmodule
